// File: common/dse_cfg.svh
// Constants for the decimal adjust, skip and branch execution block
`ifndef DSE_CFG_SVH
`define DSE_CFG_SVH
`define DSE_NIBBLE_LIMIT 4'h9
`define DSE_BCD_FIX 4'h6
`define DSE_GIE_RESET 1'b0
`define DSE_ACC_RESET 8'h00
`define DSE_PC_RESET 11'h000
`define DSE_PCH_LO 1
`define DSE_PCH_HI 2
`endif

// File: common/dse_pkg.sv
// Types for the decimal adjust, skip and branch execution block
package dse_pkg;
  typedef enum logic [2:0] {
    DSE_OP_NONE,
    DSE_OP_DECIMAL_ADJUST,
    DSE_OP_DECREMENT_SKIP,
    DSE_OP_IRQ_DISABLE,
    DSE_OP_IRQ_ENABLE,
    DSE_OP_BRANCH
  } dse_op_t;

  typedef struct packed {
    logic valid;
    dse_op_t op;
    logic [6:0] regAddr;
    logic destReg;
    logic [8:0] imm;
    logic addCarry;
    logic addHalfCarry;
  } dse_instr_t;

  typedef struct packed {
    logic [7:0] accumulator;
    logic carry;
    logic globalIrqEnable;
    logic [10:0] pc;
    logic pcLoad;
    logic flush;
    logic regWrite;
    logic [6:0] regWrAddr;
    logic [7:0] regWrData;
    logic busy;
  } dse_state_t;
endpackage

// File: hdl/dse_exec.sv
// Execution of decimal adjust, decrement-skip, irq enable/disable and branch
// Function
// - Decimal adjust converts accumulator sum to BCD
// - Decrement register, result to accumulator or register
// - Zero result flushes prefetched instruction
// - Decrement-skip one cycle, two when skipping
// - Interrupt disable clears global enable, one cycle
// - Branch loads immediate and buffer page bits
// - Branch always taken, two cycles, flushes prefetch
// - Interrupt enable sets global enable
`timescale 1ns/1ps
`include "dse_cfg.svh"
module dse_exec
  import dse_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire dse_instr_t instr,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] pcHighBuffer,
  output logic [6:0] regRdAddr,
  output dse_state_t status
);
  dse_state_t st;
  dse_state_t next_st;

  // Add six to a nibble when over nine or carried out
  function automatic logic [4:0] bcdFix(input logic [3:0] nib, input logic cin);
    bcdFix = (nib > `DSE_NIBBLE_LIMIT || cin) ? {1'b0, nib} + {1'b0, `DSE_BCD_FIX}
                                              : {1'b0, nib};
  endfunction

  // One less than the register content, wrapping at zero
  function automatic logic [7:0] decByOne(input logic [7:0] value);
    decByOne = value - 8'h01;
  endfunction

  // Skip decided on the operand, so no wait for the subtraction
  function automatic logic skipsNext(input logic [7:0] value);
    skipsNext = (value == 8'h01);
  endfunction

  logic [4:0] loFix;
  logic [4:0] hiFix;
  logic hiNeeds;
  logic [7:0] decValue;
  logic takeOp;
  // Decoded strobes of accepted instructions, for the checks below
  logic doAdjust;
  logic doDecSkip;
  logic doIrqOff;
  logic doIrqOn;
  logic doBranch;

  assign regRdAddr = instr.regAddr;
  assign status = st;
  // Slot after a flush is the discarded prefetch, executed as a no-operation
  assign takeOp = instr.valid && !st.busy;
  assign doAdjust = takeOp && instr.op == DSE_OP_DECIMAL_ADJUST;
  assign doDecSkip = takeOp && instr.op == DSE_OP_DECREMENT_SKIP;
  assign doIrqOff = takeOp && instr.op == DSE_OP_IRQ_DISABLE;
  assign doIrqOn = takeOp && instr.op == DSE_OP_IRQ_ENABLE;
  assign doBranch = takeOp && instr.op == DSE_OP_BRANCH;

  always_comb begin
    loFix = bcdFix(st.accumulator[3:0], instr.addHalfCarry);
    // A nine in the high digit overflows once the low digit carries into it
    hiNeeds = (st.accumulator[7:4] > `DSE_NIBBLE_LIMIT) || instr.addCarry ||
              (loFix[4] && st.accumulator[7:4] == `DSE_NIBBLE_LIMIT);
    hiFix = bcdFix(st.accumulator[7:4] + {3'b000, loFix[4]}, hiNeeds);
    decValue = 8'h00;
    decValue = {hiFix[3:0], loFix[3:0]};
    next_st = st;
    next_st.pcLoad = 1'b0;
    next_st.flush = 1'b0;
    next_st.regWrite = 1'b0;
    next_st.busy = 1'b0;
    if (takeOp) begin
      unique case (instr.op)
        DSE_OP_NONE: begin
        end
        DSE_OP_DECIMAL_ADJUST: begin
          next_st.accumulator = decValue;
          next_st.carry = hiFix[4] || hiNeeds;
        end
        DSE_OP_DECREMENT_SKIP: begin
          if (instr.destReg) begin
            next_st.regWrite = 1'b1;
            next_st.regWrAddr = instr.regAddr;
            next_st.regWrData = decByOne(regRdData);
          end else begin
            next_st.accumulator = decByOne(regRdData);
          end
          if (skipsNext(regRdData)) begin
            next_st.flush = 1'b1;
            next_st.busy = 1'b1;
          end
        end
        DSE_OP_IRQ_DISABLE: next_st.globalIrqEnable = 1'b0;
        DSE_OP_IRQ_ENABLE: next_st.globalIrqEnable = 1'b1;
        DSE_OP_BRANCH: begin
          next_st.pc = {pcHighBuffer[`DSE_PCH_HI:`DSE_PCH_LO], instr.imm};
          next_st.pcLoad = 1'b1;
          next_st.flush = 1'b1;
          next_st.busy = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{accumulator: `DSE_ACC_RESET, carry: 1'b0, globalIrqEnable: `DSE_GIE_RESET,
              pc: `DSE_PC_RESET, pcLoad: 1'b0, flush: 1'b0, regWrite: 1'b0,
              regWrAddr: 7'h00, regWrData: 8'h00, busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Per-instruction results: decrement-skip, interrupt disable/enable, branch and adjust
  skip_two_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_DECREMENT_SKIP && regRdData == 8'h01)
    |=> st.flush && st.busy ##1 !st.busy)
    else $error("decrement skip not two cycles");
  no_skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_DECREMENT_SKIP && regRdData != 8'h01) |=> !st.flush)
    else $error("decrement flushed on nonzero");
  dec_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_DECREMENT_SKIP && instr.destReg)
    |=> st.regWrite && st.regWrData == $past(regRdData) - 8'h01)
    else $error("decrement result wrong");
  dec_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_DECREMENT_SKIP && !instr.destReg)
    |=> !st.regWrite && st.accumulator == $past(regRdData) - 8'h01)
    else $error("decrement to accumulator wrong");
  irq_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_IRQ_DISABLE) |=> !st.globalIrqEnable)
    else $error("interrupt disable failed");
  irq_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_IRQ_ENABLE) |=> st.globalIrqEnable)
    else $error("interrupt enable failed");
  branch_target_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_BRANCH)
    |=> st.pcLoad && st.pc == {$past(pcHighBuffer[2:1]), $past(instr.imm)})
    else $error("branch target wrong");
  branch_flush_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_BRANCH)
    |=> st.flush && st.busy ##1 !st.pcLoad && !st.flush && !st.busy)
    else $error("branch not two cycles");
  adjust_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (takeOp && instr.op == DSE_OP_DECIMAL_ADJUST && !instr.addCarry && !instr.addHalfCarry
     && st.accumulator[3:0] < 4'ha && st.accumulator[7:4] < 4'ha)
    |=> $stable(st.accumulator) && !st.carry)
    else $error("adjust altered valid decimal");

  // Discarded prefetch must leave no trace at all
  refused_slot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.busy && instr.valid)
    |=> !st.regWrite && !st.pcLoad && !st.flush && !st.busy
        && $stable(st.accumulator) && $stable(st.globalIrqEnable))
    else $error("discarded slot executed");
  busy_single_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.busy |=> !st.busy)
    else $error("stall longer than one slot");
  noskip_one_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doDecSkip && !skipsNext(regRdData)) |=> !st.busy)
    else $error("decrement without skip stalled");
  skip_zero_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doDecSkip && instr.destReg && skipsNext(regRdData)) |=> st.regWrData == 8'h00)
    else $error("skip taken on nonzero result");
  dec_write_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doDecSkip && instr.destReg) |=> st.regWrAddr == $past(instr.regAddr))
    else $error("decrement wrote wrong register");
  dec_no_branch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    doDecSkip |=> !st.pcLoad)
    else $error("decrement loaded the counter");

  // Adjust touches only accumulator and carry, in one cycle
  adjust_digits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doAdjust && !instr.addCarry && !instr.addHalfCarry)
    |=> st.accumulator[3:0] < 4'ha && st.accumulator[7:4] < 4'ha)
    else $error("adjust left a non-decimal digit");
  adjust_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doAdjust && instr.addCarry) |=> st.carry)
    else $error("adjust dropped decimal carry");
  adjust_scope_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    doAdjust |=> !st.busy && !st.regWrite && !st.pcLoad && $stable(st.pc)
    && $stable(st.globalIrqEnable))
    else $error("adjust touched more than carry");
  carry_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !doAdjust |=> $stable(st.carry))
    else $error("carry changed outside adjust");
  acc_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(doAdjust || (doDecSkip && !instr.destReg)) |=> $stable(st.accumulator))
    else $error("accumulator changed unasked");

  // Global enable moves only on its own two instructions
  irq_one_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doIrqOff || doIrqOn) |=> !st.busy && !st.flush)
    else $error("interrupt op stalled");
  irq_no_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (doIrqOff || doIrqOn) |=> !st.regWrite && !st.pcLoad && $stable(st.accumulator))
    else $error("interrupt op touched other state");
  gie_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(doIrqOff || doIrqOn) |=> $stable(st.globalIrqEnable))
    else $error("interrupt enable changed unasked");

  // Program counter is only ever loaded by the branch
  pc_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !doBranch |=> $stable(st.pc) && !st.pcLoad)
    else $error("counter moved without branch");
  branch_no_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    doBranch |=> !st.regWrite && $stable(st.accumulator) && $stable(st.carry))
    else $error("branch touched data state");
  load_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.pcLoad |=> !st.pcLoad)
    else $error("counter load held too long");
endmodule // dse_exec

// File: testbench/dse_regfile.sv
// File register bank model facing the register port
`timescale 1ns/1ps
module dse_regfile
  import dse_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [6:0] regRdAddr,
  input wire dse_state_t status,
  output logic [7:0] regRdData
);
  logic [7:0] mem [128];
  assign regRdData = mem[regRdAddr];
  always @(posedge ref_clk) begin
    if (status.regWrite) mem[status.regWrAddr] <= status.regWrData;
  end
endmodule // dse_regfile

// File: testbench/testbench.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
module testbench;
  import dse_pkg::*;
  logic ref_clk, rst_n;
  dse_instr_t instr;
  logic [2:0] pcHighBuffer;
  logic [7:0] regRdData, a;
  logic [6:0] regRdAddr;
  logic [8:0] s;
  logic hc;
  dse_state_t status;
  int failures, n_tests;
  logic [31:0] sd;
  dse_exec DUT (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr), .regRdData(regRdData),
    .pcHighBuffer(pcHighBuffer), .regRdAddr(regRdAddr), .status(status));
  dse_regfile P (.ref_clk(ref_clk), .regRdAddr(regRdAddr), .status(status),
    .regRdData(regRdData));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [8:0] bcd(logic [7:0] v, logic c, logic h);
    logic [8:0] r;
    r = {c, v};
    if (h || v[3:0] > 4'h9) r[7:0] = r[7:0] + 8'h06;
    if (c || v > 8'h99) r = {1'b1, r[7:0] + 8'h60};
    return r;
  endfunction
  task automatic chk(logic [15:0] g, logic [15:0] x);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Chase puts an enable op in the discarded slot
  task automatic run(dse_op_t op, logic [6:0] r, logic d, logic [8:0] im, logic c, logic h,
      logic chase);
    @(posedge ref_clk);
    instr <= '{1'b1, op, r, d, im, c, h};
    @(posedge ref_clk);
    instr.valid <= chase;
    instr.op <= DSE_OP_IRQ_ENABLE;
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    instr = '0;
    pcHighBuffer = 3'h0;
    sd = 32'd72223;
    repeat (20) @(posedge ref_clk);
    chk(16'({status.globalIrqEnable, status.busy, status.accumulator}), 16'h0000);
    rst_n <= 1'b1;
    run(DSE_OP_IRQ_ENABLE, 7'h00, 1'b0, 9'h000, 1'b0, 1'b0, 1'b0);
    chk(16'(status.globalIrqEnable), 16'h0001);
    run(DSE_OP_IRQ_DISABLE, 7'h00, 1'b0, 9'h000, 1'b0, 1'b0, 1'b0);
    chk(16'(status.globalIrqEnable), 16'h0000);
    P.mem[127] = 8'h01;
    run(DSE_OP_DECREMENT_SKIP, 7'h7f, 1'b1, 9'h000, 1'b0, 1'b0, 1'b1);
    chk(16'({status.flush, status.busy}), 16'h0003);
    chk(16'({status.regWrite, status.regWrAddr, status.regWrData}), 16'hff00);
    chk(16'(regRdAddr), 16'h007f);
    @(posedge ref_clk);
    instr.valid <= 1'b0;
    #1;
    chk(16'({status.globalIrqEnable, status.busy, status.regWrite}), 16'h0000);
    chk(16'(P.mem[127]), 16'h0000);
    // Reset in mid-run must clear the global enable again
    run(DSE_OP_IRQ_ENABLE, 7'h00, 1'b0, 9'h000, 1'b0, 1'b0, 1'b0);
    chk(16'(status.globalIrqEnable), 16'h0001);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1;
    chk(16'({status.globalIrqEnable, status.pc}), 16'h0000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    $display("done: irq, skip and reset");
    for (int i = 0; i < 30; i++) begin
      sd = lfsr(sd);
      a = {4'(sd[3:0] % 10), 4'(sd[7:4] % 10)};
      s = {1'b0, a} + {5'h00, 4'(sd[11:8] % 10)} + {1'b0, 4'(sd[15:12] % 10), 4'h0};
      hc = (a[3:0] + 5'(sd[11:8] % 10)) > 5'h0f;
      P.mem[sd[22:16]] = s[7:0] + 8'h01;
      run(DSE_OP_IRQ_DISABLE, 7'h00, 1'b0, 9'h000, 1'b0, 1'b0, 1'b0);
      chk(16'(status.globalIrqEnable), 16'h0000);
      run(DSE_OP_DECREMENT_SKIP, sd[22:16], 1'b0, 9'h000, 1'b0, 1'b0, 1'b0);
      chk(16'({status.flush, status.regWrite}), {14'h0000, s[7:0] == 8'h00, 1'b0});
      chk(16'(status.accumulator), {8'h00, s[7:0]});
      run(DSE_OP_DECIMAL_ADJUST, 7'h00, 1'b0, 9'h000, s[8], hc, 1'b0);
      chk(16'({status.carry, status.accumulator}), 16'(bcd(s[7:0], s[8], hc)));
      run(DSE_OP_IRQ_ENABLE, 7'h00, 1'b0, 9'h000, 1'b0, 1'b0, 1'b0);
      chk(16'(status.globalIrqEnable), 16'h0001);
      pcHighBuffer <= sd[26:24];
      run(DSE_OP_BRANCH, 7'h00, 1'b0, sd[31:23], 1'b0, 1'b0, 1'b0);
      chk(16'(status.pc), {5'h00, sd[26:25], sd[31:23]});
      chk(16'({status.pcLoad, status.flush, status.busy}), 16'h0007);
    end
    $display("done: adjust and branch");
    report_and_stop();
  end
endmodule // testbench
